// >>> rtl/fwx_pkg.sv
// Operation
// - Even cells low half, odd cells high half
// - Cell accumulates next set after output
// - Cell select routes one accumulator everywhere
// - Enables drive low, high or all bits
// - Adder second input is buffer MSBs or zero
// - Adder result stored into buffer every clock
// - Output via direct path or adder path
// - Shift-add sums buffer down eight with cell
// - Clear low erases the selected accumulator
package fwx_pkg;

  // Datapath widths
  localparam int COEF_W = 8;
  localparam int DATA_W = 8;
  localparam int ACC_W = 26;
  localparam int LOW_W = 16;
  localparam int HIGH_W = 10;
  localparam int SHIFT_W = 8;
  localparam int ZMUX_W = 18;
  localparam int CELLS = 4;
  localparam int SEL_W = 2;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] BUF_OFS = 4'h4;
  localparam logic [3:0] OUT_OFS = 4'h8;

  // Control register fields and reset value
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic CTRL_RUN_RST = 1'b1;

  // Per-cycle sequencer controls, sampled each enabled clock
  typedef struct packed {
    logic shift_accumulate_select;
    logic [1:0] cell_select;
    logic acc_clear_n;
    logic data_zero_insert_control;
    logic low_sum_output_enable_n;
    logic high_sum_output_enable_n;
  } fwx_ctrl_type;

endpackage

// >>> rtl/fwx_cell.sv
`timescale 1ns/1ps
// One multiply-accumulate cell with coefficient pass-through
module fwx_cell #(
  parameter int CW = 8,
  parameter int DW = 8,
  parameter int AW = 26
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic run,
  input wire logic [CW-1:0] coef_in,
  input wire logic [DW-1:0] x_in,
  input wire logic erase,
  output logic [CW-1:0] coef_reg,
  output logic [AW-1:0] acc_reg
);

  logic [CW+DW-1:0] prod; // Raw product, unsigned
  logic [AW-1:0] prod_ext; // Product widened to accumulator
  logic [AW-1:0] acc_next;

  // Multiply and widen
  always_comb begin
    prod = coef_reg * x_in;
    prod_ext = {{(AW-CW-DW){1'b0}}, prod};
  end

  // Erase restarts from the product, else keep summing
  always_comb begin
    if (erase) begin
      acc_next = prod_ext;
    end else begin
      acc_next = acc_reg + prod_ext;
    end
  end

  // Coefficient moves one cell per running clock, so the stream order sets the tap
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      coef_reg <= '0;
    end else if (ce && run) begin
      coef_reg <= coef_in;
    end
  end

  // Accumulator
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg <= '0;
    end else if (ce && run) begin
      acc_reg <= acc_next;
    end
  end

  erase_start_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && run && erase) |=> (acc_reg == $past(prod_ext)))
    else $error("erase did not restart accumulator");

  keep_sum_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && run && !erase) |=> (acc_reg == $past(acc_reg) + $past(prod_ext)))
    else $error("accumulator did not add product");

endmodule

// >>> rtl/fwx_top.sv
`timescale 1ns/1ps
// Four-cell filter with shift/add output stage and a Wishbone slave
module fwx_top #(
  parameter int CW = fwx_pkg::COEF_W,
  parameter int DW = fwx_pkg::DATA_W,
  parameter int AW = fwx_pkg::ACC_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [CW-1:0] coef_in,
  input wire logic [DW-1:0] data_in,
  input wire fwx_pkg::fwx_ctrl_type ctrl_in,
  output logic [fwx_pkg::LOW_W-1:0] low_sum_bus,
  output logic low_sum_oe_n,
  output logic [fwx_pkg::HIGH_W-1:0] high_sum_bus,
  output logic high_sum_oe_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  localparam int NC = fwx_pkg::CELLS;
  localparam int SW = fwx_pkg::SEL_W;
  localparam int LW = fwx_pkg::LOW_W;
  localparam int HW = fwx_pkg::HIGH_W;
  localparam int ZW = fwx_pkg::ZMUX_W;
  localparam int SH = fwx_pkg::SHIFT_W;

  // Control register state
  logic run_reg; // Datapath runs when set
  logic clr_all_reg; // One-clock erase of every cell
  logic wb_ack_next;
  logic [31:0] wb_dat_next;

  // Datapath state
  logic [DW-1:0] x_reg; // Shared sample register
  logic [CW-1:0] coef_chain [NC+1]; // Coefficient pipeline taps
  logic [AW-1:0] acc_vec [NC]; // Accumulator of each cell
  logic [AW-1:0] cell_value; // Selected accumulator
  logic [AW-1:0] zmux_value; // Second adder input
  logic [AW-1:0] adder_sum;
  logic [AW-1:0] buf_reg; // Output buffer
  logic [AW-1:0] out_reg; // Output multiplexer register
  logic [AW-1:0] out_next;
  logic bus_req; // Wishbone request this cycle
  logic bus_wr; // Write strobe on the taken edge
  logic [AW-1:0] prod0_chk; // Cell 0 product, rebuilt for the erase checks

  assign coef_chain[0] = coef_in;

  // Check-only copy of cell 0's product; widened first so no bits are lost
  assign prod0_chk = AW'(coef_chain[1]) * AW'(x_reg);

  // Shared X register: zero slot or real sample
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      x_reg <= '0;
    end else if (ce && run_reg) begin
      if (ctrl_in.data_zero_insert_control) begin
        x_reg <= '0;
      end else begin
        x_reg <= data_in;
      end
    end
  end

  // Cells; coefficient chain means even cells see low halves in order
  for (genvar k = 0; k < NC; k++) begin : g_cell
    logic erase_k; // Clear request for this cell
    assign erase_k = clr_all_reg ||
                     (!ctrl_in.acc_clear_n && (ctrl_in.cell_select == SW'(k)));
    fwx_cell #(
      .CW(CW),
      .DW(DW),
      .AW(AW)
    ) u_cell (
      .clk(clk),
      .arst_n(arst_n),
      .ce(ce),
      .run(run_reg),
      .coef_in(coef_chain[k]),
      .x_in(x_reg),
      .erase(erase_k),
      .coef_reg(coef_chain[k+1]),
      .acc_reg(acc_vec[k])
    );
  end

  // Cell select feeds both adder and output mux
  always_comb begin
    cell_value = acc_vec[ctrl_in.cell_select];
  end

  // Zero mux and shift/add adder
  always_comb begin
    if (ctrl_in.shift_accumulate_select) begin
      zmux_value = {{(AW-ZW){1'b0}}, buf_reg[AW-1:SH]};
    end else begin
      zmux_value = '0;
    end
    adder_sum = cell_value + zmux_value;
  end

  // Route choice: adder path during shift/add, direct path otherwise
  always_comb begin
    if (ctrl_in.shift_accumulate_select) begin
      out_next = adder_sum;
    end else begin
      out_next = cell_value;
    end
  end

  // Output buffer captures every sum, so the next step can shift it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      buf_reg <= '0;
    end else if (ce) begin
      buf_reg <= adder_sum;
    end
  end

  // Output multiplexer register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_reg <= '0;
    end else if (ce) begin
      out_reg <= out_next;
    end
  end

  // Split output enables; low enable pin drives the low 16, high the top 10
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_sum_oe_n <= 1'b1;
      high_sum_oe_n <= 1'b1;
    end else if (ce) begin
      low_sum_oe_n <= ctrl_in.low_sum_output_enable_n;
      high_sum_oe_n <= ctrl_in.high_sum_output_enable_n;
    end
  end

  // Bus halves come straight from the output register
  always_comb begin
    low_sum_bus = out_reg[LW-1:0];
    high_sum_bus = out_reg[AW-1:LW];
  end

  // Wishbone request decode
  always_comb begin
    bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    wb_ack_next = bus_req;
  end

  // Read mux; unmapped offsets read zero but still ack
  always_comb begin
    wb_dat_next = 32'h0000_0000;
    case (wb_adr_i)
      fwx_pkg::CTRL_OFS: begin
        wb_dat_next[fwx_pkg::CTRL_RUN_BIT] = run_reg;
      end
      fwx_pkg::BUF_OFS: begin
        wb_dat_next[AW-1:0] = buf_reg;
      end
      fwx_pkg::OUT_OFS: begin
        wb_dat_next[AW-1:0] = out_reg;
      end
      default: begin
        wb_dat_next = 32'h0000_0000;
      end
    endcase
  end

  // Ack one clock after the request, dropped the next clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= wb_ack_next;
      wb_dat_o <= wb_dat_next;
    end
  end

  // Run bit; clear stops the cells, coefficient chain and X register (buffer and output keep loading) so software can freeze for readout
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_reg <= fwx_pkg::CTRL_RUN_RST;
    end else if (ce && bus_wr && (wb_adr_i == fwx_pkg::CTRL_OFS)) begin
      run_reg <= wb_dat_i[fwx_pkg::CTRL_RUN_BIT];
    end
  end

  // Clear-all pulse, self clearing after one enabled clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clr_all_reg <= 1'b0;
    end else if (ce) begin
      clr_all_reg <= bus_wr && (wb_adr_i == fwx_pkg::CTRL_OFS) &&
                     wb_dat_i[fwx_pkg::CTRL_CLR_BIT];
    end
  end

  // Checks
  // One shift/add step
  sequence shift_accumulate_select_step_s;
    ce && ctrl_in.shift_accumulate_select;
  endsequence

  // One direct-path step
  sequence direct_step_s;
    ce && !ctrl_in.shift_accumulate_select;
  endsequence

  // Cell 0 erased by its own clear, not by the clear-all pulse
  sequence erase_cell0_s;
    ce && run_reg && !ctrl_in.acc_clear_n && !clr_all_reg && ctrl_in.cell_select == 2'h0;
  endsequence

  // Adder path output is the cell plus the shifted buffer
  shift_add_a: assert property (@(posedge clk) disable iff (!arst_n)
    shift_accumulate_select_step_s |=> (out_reg == $past(cell_value) + (($past(buf_reg)) >> SH)))
    else $error("shift-add result wrong");

  // Zero mux feeds nothing on direct steps
  zero_mux_a: assert property (@(posedge clk) disable iff (!arst_n)
    direct_step_s |=> (buf_reg == $past(cell_value)))
    else $error("zero mux not zero");

  // Direct path shows the selected accumulator
  direct_path_a: assert property (@(posedge clk) disable iff (!arst_n)
    direct_step_s |=> (out_reg == $past(acc_vec[ctrl_in.cell_select])))
    else $error("direct path wrong cell");

  // Buffer and output register take the same sum
  buf_out_a: assert property (@(posedge clk) disable iff (!arst_n)
    shift_accumulate_select_step_s |=> (buf_reg == out_reg))
    else $error("buffer not holding latest sum");

  // Low enable follows its control one clock later
  low_enable_a: assert property (@(posedge clk) disable iff (!arst_n)
    ce |=> (low_sum_oe_n == $past(ctrl_in.low_sum_output_enable_n)))
    else $error("low enable not followed");

  // High enable follows its control one clock later
  high_enable_a: assert property (@(posedge clk) disable iff (!arst_n)
    ce |=> (high_sum_oe_n == $past(ctrl_in.high_sum_output_enable_n)))
    else $error("high enable not followed");

  // Bus halves are fixed slices of the output register
  high_field_a: assert property (@(posedge clk) disable iff (!arst_n)
    (high_sum_bus == out_reg[AW-1:LW]) && (low_sum_bus == out_reg[LW-1:0]))
    else $error("bus halves misplaced");

  // Erased cell restarts from the single product of its erase clock
  cell_erase_a: assert property (@(posedge clk) disable iff (!arst_n)
    erase_cell0_s
    ##1 (ce && run_reg && ctrl_in.cell_select == 2'h0 && !ctrl_in.shift_accumulate_select)
    |=> (out_reg == $past(prod0_chk, 2)))
    else $error("erased cell path wrong");

  // Shift/add after a direct step uses the cell shown one step earlier
  shift_accumulate_select_chain_a: assert property (@(posedge clk) disable iff (!arst_n)
    direct_step_s ##1 shift_accumulate_select_step_s |=>
    (out_reg == $past(cell_value) + ($past(cell_value, 2) >> SH)))
    else $error("two-step shift-add wrong");

  // Zero insert loads an empty sample
  zero_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && run_reg && ctrl_in.data_zero_insert_control) |=> (x_reg == '0))
    else $error("zero slot not loaded");

  // Coefficients step one cell per running clock
  coef_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && run_reg) |=> (coef_chain[2] == $past(coef_chain[1])))
    else $error("coefficient chain stalled");

  // Clear-all restarts every cell; cell 0 stands for the group
  clear_all_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && run_reg && clr_all_reg) |=> (acc_vec[0] == $past(prod0_chk)))
    else $error("clear-all did not restart cell");

  // Stopped run freezes the accumulators
  run_freeze_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && !run_reg) |=> (acc_vec[0] == $past(acc_vec[0])))
    else $error("stopped cell still moved");

  // Ack is a single pulse one clock after the request
  wb_ack_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 (ce -> !wb_ack_o))
    else $error("wishbone ack timing wrong");

  // Output word read back as it stood when the request was taken
  out_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && bus_req && !wb_we_i && wb_adr_i == fwx_pkg::OUT_OFS) |=>
    (wb_dat_o[AW-1:0] == $past(out_reg)))
    else $error("output read data wrong");

endmodule

// >>> tb/fwx_capture.sv
`timescale 1ns/1ps
// External result registers beside the filter's sum bus
module fwx_capture (
  input wire logic clk,
  input wire logic [15:0] sum_bus,
  input wire logic take_lo,
  input wire logic take_hi,
  output logic [31:0] y
);
  logic [7:0] lo_reg; // Low byte of one result
  logic [15:0] hi_reg; // Shifted high word
  // Low byte must be used before the next one lands
  always_ff @(posedge clk) begin
    if (take_lo) begin
      lo_reg <= sum_bus[7:0];
    end
    if (take_hi) begin
      hi_reg <= sum_bus;
    end
  end
  // High word weighted by 256
  assign y = {8'h00, hi_reg, 8'h00} + {24'h000000, lo_reg};
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] C = 8'h30; // Same coefficient in every stream slot
  localparam logic [7:0] D = 8'h41; // Same sample every clock, as if re-fed
  localparam logic [25:0] P = {18'h00000, C} * {18'h00000, D}; // One product
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  fwx_pkg::fwx_ctrl_type ctrl_in = 7'h08; // Clear inactive, sums enabled
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd, y, hold;
  logic [15:0] lo_bus;
  logic [9:0] hi_bus;
  logic lo_oe_n, hi_oe_n, ack;
  logic take_lo = 1'h0, take_hi = 1'h0, dz = 1'h0, lo_n = 1'h0, hi_n = 1'h0;
  int err_total = 0, samples_checked = 0, ecnt = 0, n;
  int e[4]; // Edge number at which each cell was erased
  logic [25:0] bufm, exp_v; // Expected output buffer and output
  always #20 clk = ~clk;
  always @(posedge clk) ecnt <= ecnt + 1;
  fwx_top dut (.clk(clk), .arst_n(arst_n), .ce(1'h1), .coef_in(C), .data_in(D),
    .ctrl_in(ctrl_in), .low_sum_bus(lo_bus), .low_sum_oe_n(lo_oe_n), .high_sum_bus(hi_bus),
    .high_sum_oe_n(hi_oe_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  fwx_capture cap (.clk(clk), .sum_bus(lo_bus), .take_lo(take_lo), .take_hi(take_hi), .y(y));
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One edge under given controls; all cells gain one product per running edge
  task automatic step(input int s, input logic clr_n, input logic sh, input logic chk);
    logic [25:0] cv;
    ctrl_in <= {sh, 2'(s), clr_n, dz, lo_n, hi_n};
    @(posedge clk);
    #1;
    n = ecnt;
    cv = 26'(n - e[s]) * P;
    exp_v = sh ? cv + {8'h00, bufm[25:8]} : cv;
    bufm = exp_v;
    if (!clr_n) begin
      e[s] = n;
    end
    if (chk) begin
      check({6'h00, hi_bus, lo_bus}, {6'h00, exp_v});
    end
  endtask
  // Classic single cycle; wait for ack with a bound
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'h1 && i < 20);
    if (ack !== 1'h1) begin
      err_total++;
      complete_run();
    end
    rd = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic t_cells;
    for (int k = 0; k < 4; k++) begin
      step(k, 1'h0, 1'h0, 1'h0);
      step(k, 1'h1, 1'h0, 1'h1);
      step(k, 1'h1, 1'h0, 1'h1);
    end
    $display("erase and accumulate done");
  endtask
  task automatic t_shift;
    step(0, 1'h0, 1'h0, 1'h0);
    step(1, 1'h0, 1'h0, 1'h0);
    step(0, 1'h1, 1'h0, 1'h1);
    take_lo <= 1'h1;
    step(1, 1'h1, 1'h1, 1'h1);
    take_lo <= 1'h0;
    take_hi <= 1'h1;
    step(1, 1'h1, 1'h1, 1'h1);
    take_hi <= 1'h0;
    check(y, 32'(P * 2 * 257));
    $display("shift add done");
  endtask
  // Sum past the low 16 bits into the high bus while the enables walk every pairing
  task automatic t_wide;
    step(2, 1'h0, 1'h0, 1'h0);
    for (int i = 0; i < 40; i++) begin
      {hi_n, lo_n} = 2'(i);
      step(2, 1'h1, 1'h0, 1'h1);
      check({hi_oe_n, lo_oe_n}, {hi_n, lo_n});
    end
    {hi_n, lo_n} = 2'h0;
    $display("wide sum and enables done");
  endtask
  // Run off freezes cells; buffer and output then readable as stable words
  task automatic t_regs;
    wb(1'h0, fwx_pkg::CTRL_OFS, 32'h0);
    check(rd, 32'h1);
    wb(1'h1, fwx_pkg::CTRL_OFS, 32'h0);
    step(0, 1'h1, 1'h0, 1'h0);
    hold = {6'h00, hi_bus, lo_bus};
    step(0, 1'h1, 1'h0, 1'h0);
    check({6'h00, hi_bus, lo_bus}, hold);
    wb(1'h0, fwx_pkg::OUT_OFS, 32'h0);
    check(rd, hold);
    wb(1'h0, fwx_pkg::BUF_OFS, 32'h0);
    check(rd, hold);
    wb(1'h1, fwx_pkg::CTRL_OFS, 32'h3);
    for (int k = 0; k < 4; k++) begin
      e[k] = ecnt + 1; // Clear-all erases every cell one edge after the ack edge
    end
    wb(1'h0, fwx_pkg::CTRL_OFS, 32'h0);
    check(rd, 32'h1);
    wb(1'h0, 4'hC, 32'h0);
    check(rd, 32'h0);
    step(1, 1'h1, 1'h0, 1'h1);
    $display("registers done");
  endtask
  task automatic t_zero;
    dz = 1'h1;
    step(0, 1'h1, 1'h0, 1'h0);
    step(0, 1'h0, 1'h0, 1'h0);
    step(0, 1'h1, 1'h0, 1'h0);
    check({6'h00, hi_bus, lo_bus}, 32'h0);
    dz = 1'h0;
    $display("zero insert done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    check({4'h0, hi_oe_n, lo_oe_n, hi_bus, lo_bus}, 32'h0C000000);
    arst_n <= 1'h1;
    repeat (6) step(0, 1'h1, 1'h0, 1'h0);
    t_cells();
    t_shift();
    t_wide();
    t_regs();
    t_zero();
    complete_run();
  end
  // Hang guard
  initial begin
    #2000000;
    err_total++;
    complete_run();
  end
endmodule
